// ==== rtc_update_irq.sv ====
// Purpose: time update and countdown interrupt logic with register port
// Assumes: host reaches registers over a plain strobe port, data a cycle later
// Notes:   open-drain interrupt pin appears as a low output and an enable
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [R1] countdown interval is preset times source period; zero preset gives nothing
// [R2] first countdown interval may be off by one source period
// [R3] countdown starts on the write that takes the run bit from 0 to 1
// [R4] period select 0 picks second events, 1 picks minute events
// [R5] every update event sets the update flag regardless of mask
// [R6] update flag holds until written 0; writing 1 does nothing
// [R7] event drives the interrupt low only when the update mask is 1
// [R8] low output releases automatically after 7.813 ms, relowers next event
// [R9] clearing the update flag releases the output at once
// [R10] mask going 1 to 0 releases the output at once
// [R11] while the clock reset bit is 1 no update events happen
// [R12] event generator always runs; mask only gates the output
// [R13] host should clear the mask before changing settings
// [R14] fixed-zero bits ignore writes and read as zero
// [R15] select, flag and mask sit at bit 5, each register mirrored
// [R16] output is shared, other sources may hold it low
// [R17] output is open drain, low while any enabled source asserts
// [R18] update event is a one-cycle pulse on counter rollover
module rtc_update_irq #(
   parameter int TICK_DIV   = rtc_irq_pkg::TICK_CYCLES,
   parameter int RTN_SLOW   = rtc_irq_pkg::RTN_SLOW_CYCLES,
   parameter int RTN_FAST   = rtc_irq_pkg::RTN_FAST_CYCLES
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   output logic      [7:0] rdata,
   // open-drain interrupt pin
   output logic            irq_n_out,
   output logic            irq_oe
);

   // ==========================================================
   // declarations
   timebase_if tb ();

   logic [7:0]  func_sel_r;
   logic [7:0]  irq_ctrl_r;
   logic [7:0]  preset_lo_r;
   logic [7:0]  preset_hi_r;
   logic        upd_flag_r;
   logic        cd_flag_r;
   logic        upd_drive_r;
   logic        cd_drive_r;
   logic [23:0] upd_rtn_r;
   logic [23:0] cd_rtn_r;
   logic        cd_expire;
   logic        upd_evt;
   logic        sel_ok;
   logic        wr_func;
   logic        wr_flags;
   logic        wr_ctrl;
   logic        wr_plo;
   logic        wr_phi;
   logic        cd_start;
   logic        upd_mask_fall;
   logic        cd_mask_fall;
   logic        upd_clear;
   logic        cd_clear;
   logic [23:0] cd_rtn_len;

   // ==========================================================
   // address decode
   // both the 0x0x and 0x1x pages select the same register
   function automatic logic hits(input logic [7:0] a, input logic [3:0] ofs);
      hits = (a[7:5] == 3'h0) && (a[3:0] == ofs);
   endfunction

   assign sel_ok   = (addr[7:5] == 3'h0) && (addr[3:0] >= rtc_irq_pkg::OFS_PRESET_LO);
   assign wr_func  = wr_stb && hits(addr, rtc_irq_pkg::OFS_FUNC_SEL);    // [R15]
   assign wr_flags = wr_stb && hits(addr, rtc_irq_pkg::OFS_EVT_FLAGS);   // [R15]
   assign wr_ctrl  = wr_stb && hits(addr, rtc_irq_pkg::OFS_IRQ_CTRL);    // [R15]
   assign wr_plo   = wr_stb && hits(addr, rtc_irq_pkg::OFS_PRESET_LO);
   assign wr_phi   = wr_stb && hits(addr, rtc_irq_pkg::OFS_PRESET_HI);

   // ==========================================================
   // submodules
   rtc_timebase #(
      .TICK_DIV (TICK_DIV)
   ) u_timebase (
      .clock (clock),
      .nrst  (nrst),
      .tb    (tb)
   );

   rtc_countdown #(
      .W (rtc_irq_pkg::PRESET_W)
   ) u_countdown (
      .clock   (clock),
      .nrst    (nrst),
      .tb      (tb),
      .run     (func_sel_r[rtc_irq_pkg::BIT_CD_RUN]),
      .start   (cd_start),
      .src_sel (func_sel_r[1:0]),
      .preset  ({preset_hi_r[3:0], preset_lo_r}),
      .expire  (cd_expire)
   );

   // ==========================================================
   // write-side effects
   // run bit rising loads the preset in the same write cycle
   assign cd_start      = wr_func && wdata[rtc_irq_pkg::BIT_CD_RUN]
                          && !func_sel_r[rtc_irq_pkg::BIT_CD_RUN];          // [R3]
   assign upd_mask_fall = wr_ctrl && !wdata[rtc_irq_pkg::BIT_UPD_MASK]
                          && irq_ctrl_r[rtc_irq_pkg::BIT_UPD_MASK];         // [R10]
   assign cd_mask_fall  = wr_ctrl && !wdata[rtc_irq_pkg::BIT_CD_MASK]
                          && irq_ctrl_r[rtc_irq_pkg::BIT_CD_MASK];
   assign upd_clear     = wr_flags && !wdata[rtc_irq_pkg::BIT_UPD_FLAG];    // [R6]
   assign cd_clear      = wr_flags && !wdata[rtc_irq_pkg::BIT_CD_FLAG];

   // update event source: second or minute rollover, held off by clock reset
   // the generator itself never stops; only the mask gates the pin
   assign upd_evt = (func_sel_r[rtc_irq_pkg::BIT_UPD_SEL] ? tb.min_evt : tb.sec_evt)   // [R4]
                    && !irq_ctrl_r[rtc_irq_pkg::BIT_CLK_RESET];                        // [R11] [R12]

   // ==========================================================
   // plain read/write registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         func_sel_r <= rtc_irq_pkg::RST_FUNC_SEL;
      end else if (wr_func) begin
         func_sel_r <= wdata & rtc_irq_pkg::MASK_FUNC_SEL;
      end
   end

   // fixed-zero control bits never store
   always_ff @(posedge clock) begin
      if (!nrst) begin
         irq_ctrl_r <= rtc_irq_pkg::RST_IRQ_CTRL;
      end else if (wr_ctrl) begin
         irq_ctrl_r <= wdata & rtc_irq_pkg::MASK_IRQ_CTRL;   // [R14]
      end
   end

   // preset halves; host should stop the countdown before rewriting
   always_ff @(posedge clock) begin
      if (!nrst) begin
         preset_lo_r <= rtc_irq_pkg::RST_PRESET;
         preset_hi_r <= rtc_irq_pkg::RST_PRESET;
      end else begin
         if (wr_plo) begin
            preset_lo_r <= wdata;
         end
         if (wr_phi) begin
            preset_hi_r <= wdata & rtc_irq_pkg::MASK_PRESET_HI;
         end
      end
   end

   // ==========================================================
   // sticky flags; a same-cycle event beats the software clear
   always_ff @(posedge clock) begin
      if (!nrst) begin
         upd_flag_r <= 1'b0;
      end else if (upd_evt) begin
         upd_flag_r <= 1'b1;                                  // [R5]
      end else if (upd_clear) begin
         upd_flag_r <= 1'b0;                                  // [R6]
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cd_flag_r <= 1'b0;
      end else if (cd_expire) begin
         cd_flag_r <= 1'b1;
      end else if (cd_clear) begin
         cd_flag_r <= 1'b0;
      end
   end

   // ==========================================================
   // update drive: timed low pulse per event
   // restart wins over a flag-clear release in the same cycle; a mask fall wins over restart
   always_ff @(posedge clock) begin
      if (!nrst) begin
         upd_drive_r <= 1'b0;
         upd_rtn_r   <= 24'h000000;
      end else if (upd_evt && irq_ctrl_r[rtc_irq_pkg::BIT_UPD_MASK] && !upd_mask_fall) begin
         upd_drive_r <= 1'b1;                                 // [R7] [R8]
         upd_rtn_r   <= 24'(RTN_SLOW - 1);
      end else if (upd_clear || upd_mask_fall) begin
         upd_drive_r <= 1'b0;                                 // [R9] [R10]
         upd_rtn_r   <= 24'h000000;
      end else if (upd_drive_r) begin
         if (upd_rtn_r == 24'h000000) begin
            upd_drive_r <= 1'b0;                              // [R8]
         end else begin
            upd_rtn_r   <= upd_rtn_r - 24'h000001;
         end
      end
   end

   // ==========================================================
   // countdown drive: pulse length depends on the source
   // clearing its flag does not cut the pulse short; the mask does
   assign cd_rtn_len = (func_sel_r[1:0] == rtc_irq_pkg::SRC_4096HZ) ? 24'(RTN_FAST - 1)
                                                                     : 24'(RTN_SLOW - 1);

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cd_drive_r <= 1'b0;
         cd_rtn_r   <= 24'h000000;
      end else if (cd_expire && irq_ctrl_r[rtc_irq_pkg::BIT_CD_MASK] && !cd_mask_fall) begin
         cd_drive_r <= 1'b1;
         cd_rtn_r   <= cd_rtn_len;
      end else if (cd_mask_fall) begin
         cd_drive_r <= 1'b0;
         cd_rtn_r   <= 24'h000000;
      end else if (cd_drive_r) begin
         if (cd_rtn_r == 24'h000000) begin
            cd_drive_r <= 1'b0;
         end else begin
            cd_rtn_r   <= cd_rtn_r - 24'h000001;
         end
      end
   end

   // ==========================================================
   // shared open-drain pin: any source pulls it low
   assign irq_n_out = 1'b0;                                   // [R17]
   assign irq_oe    = upd_drive_r || cd_drive_r;              // [R16] [R17]

   // ==========================================================
   // read data, valid only in the cycle after the strobe
   // fixed-zero bits and unmapped addresses return zero
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd_stb && sel_ok) begin
         unique case (addr[3:0])
            rtc_irq_pkg::OFS_PRESET_LO: rdata <= preset_lo_r;
            rtc_irq_pkg::OFS_PRESET_HI: rdata <= preset_hi_r;
            rtc_irq_pkg::OFS_FUNC_SEL:  rdata <= func_sel_r;
            rtc_irq_pkg::OFS_EVT_FLAGS: rdata <= {2'b00, upd_flag_r, cd_flag_r, 4'h0};   // [R14] [R15]
            rtc_irq_pkg::OFS_IRQ_CTRL:  rdata <= irq_ctrl_r;
            default:                    rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// ==== rtc_irq_pkg.sv ====
// Purpose: shared constants of the periodic update interrupt block
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   every offset, field position, reset value and count lives here
package rtc_irq_pkg;

   // ==========================================================
   // register offsets (low nibble; the 0x1x mirror is decoded too)
   localparam logic [3:0] OFS_PRESET_LO  = 4'hb;
   localparam logic [3:0] OFS_PRESET_HI  = 4'hc;
   localparam logic [3:0] OFS_FUNC_SEL   = 4'hd;
   localparam logic [3:0] OFS_EVT_FLAGS  = 4'he;
   localparam logic [3:0] OFS_IRQ_CTRL   = 4'hf;

   // ==========================================================
   // field positions
   localparam int BIT_UPD_SEL    = 5;   // function_select
   localparam int BIT_CD_RUN     = 4;   // function_select
   localparam int BIT_UPD_FLAG   = 5;   // event_flags
   localparam int BIT_CD_FLAG    = 4;   // event_flags
   localparam int BIT_UPD_MASK   = 5;   // interrupt_control
   localparam int BIT_CD_MASK    = 4;   // interrupt_control
   localparam int BIT_CLK_RESET  = 0;   // interrupt_control

   // writable bit masks; other bits are fixed at zero
   localparam logic [7:0] MASK_FUNC_SEL  = 8'hff;
   localparam logic [7:0] MASK_IRQ_CTRL  = 8'hf9;
   localparam logic [7:0] MASK_PRESET_HI = 8'hff;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_FUNC_SEL   = 8'h00;
   localparam logic [7:0] RST_IRQ_CTRL   = 8'h00;
   localparam logic [7:0] RST_PRESET     = 8'h00;

   // ==========================================================
   // countdown source selection codes
   typedef enum logic [1:0] {
      SRC_4096HZ = 2'b00,
      SRC_64HZ   = 2'b01,
      SRC_SECOND = 2'b10,
      SRC_MINUTE = 2'b11
   } cd_src_t;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_PS    = 10000;
   localparam int SRC_PERIOD_PS    = 244140;      // 244.14 us
   localparam int TICK_CYCLES      = SRC_PERIOD_PS * 1000 / CLK_PERIOD_PS;
   localparam int TICKS_PER_64HZ   = 64;
   localparam int TICKS_PER_SEC    = 4096;
   localparam int SECS_PER_MIN     = 60;
   localparam int RTN_SLOW_NS      = 7813000;     // 7.813 ms
   localparam int RTN_FAST_NS      = 122000;      // 122 us
   localparam int RTN_SLOW_CYCLES  = (RTN_SLOW_NS * 100 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS * 10;
   localparam int RTN_FAST_CYCLES  = (RTN_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PRESET_W         = 12;

endpackage

// ==== timebase_if.sv ====
// Purpose: carries the timekeeping pulses from the timebase to its users
// Assumes: all pulses are one cycle wide on the system clock
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface timebase_if;
   logic tick_src;     // 4096 Hz
   logic tick_64;      // 64 Hz
   logic sec_evt;      // seconds rollover
   logic min_evt;      // minutes rollover
   modport src (output tick_src, output tick_64, output sec_evt, output min_evt);
   modport snk (input tick_src, input tick_64, input sec_evt, input min_evt);
endinterface
`default_nettype wire

// ==== rtc_timebase.sv ====
// Purpose: internal timekeeping clock, 4096 Hz down to minute rollover
// Assumes: tick_div system cycles per 4096 Hz tick
// Notes:   free running; never gated by register state
`timescale 1ns/1ps
`default_nettype none
module rtc_timebase #(
   parameter int TICK_DIV = rtc_irq_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic nrst,
   // pulses out
   timebase_if.src   tb
);
   logic [15:0] div_r;
   logic [11:0] sub_r;
   logic [5:0]  sec_r;
   logic        tick;

   assign tick = (div_r == 16'(TICK_DIV - 1));

   // ==========================================================
   // prescaler to the 4096 Hz source tick
   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_r <= 16'h0000;
      end else if (tick) begin
         div_r <= 16'h0000;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end

   // sub-second and seconds counters; pulses on their rollover
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sub_r       <= 12'h000;
         sec_r       <= 6'h00;
         tb.tick_src <= 1'b0;
         tb.tick_64  <= 1'b0;
         tb.sec_evt  <= 1'b0;
         tb.min_evt  <= 1'b0;
      end else begin
         tb.tick_src <= tick;
         tb.tick_64  <= tick && (sub_r[5:0] == 6'(rtc_irq_pkg::TICKS_PER_64HZ - 1));
         tb.sec_evt  <= tick && (sub_r == 12'(rtc_irq_pkg::TICKS_PER_SEC - 1));         // [R18]
         tb.min_evt  <= tick && (sub_r == 12'(rtc_irq_pkg::TICKS_PER_SEC - 1))
                        && (sec_r == 6'(rtc_irq_pkg::SECS_PER_MIN - 1));               // [R18]
         if (tick) begin
            sub_r <= sub_r + 12'h001;
            if (sub_r == 12'(rtc_irq_pkg::TICKS_PER_SEC - 1)) begin
               sec_r <= (sec_r == 6'(rtc_irq_pkg::SECS_PER_MIN - 1)) ? 6'h00 : sec_r + 6'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtc_countdown.sv ====
// Purpose: fixed-cycle countdown, preset times selected source period
// Assumes: start is a one-cycle pulse on the enabling register write
// Notes:   source phase is free, so the first interval may be off by one period
`timescale 1ns/1ps
`default_nettype none
module rtc_countdown #(
   parameter int W = rtc_irq_pkg::PRESET_W
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         nrst,
   // timebase
   timebase_if.snk           tb,
   // control
   input  wire logic         run,
   input  wire logic         start,
   input  wire logic [1:0]   src_sel,
   input  wire logic [W-1:0] preset,
   // event
   output logic              expire
);
   logic [W-1:0] cnt_r;
   logic         src_tick;

   // source period select
   always_comb begin
      unique case (rtc_irq_pkg::cd_src_t'(src_sel))
         rtc_irq_pkg::SRC_4096HZ: src_tick = tb.tick_src;
         rtc_irq_pkg::SRC_64HZ:   src_tick = tb.tick_64;
         rtc_irq_pkg::SRC_SECOND: src_tick = tb.sec_evt;
         rtc_irq_pkg::SRC_MINUTE: src_tick = tb.min_evt;
      endcase
   end

   // ==========================================================
   // count down, reload from the preset on every expiry
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cnt_r  <= '0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (start) begin
            cnt_r <= preset;                                  // [R3]
         end else if (run && src_tick && cnt_r != '0) begin   // [R2]
            if (cnt_r == W'(1)) begin
               expire <= 1'b1;                                // [R1]
               cnt_r  <= preset;
            end else begin
               cnt_r  <= cnt_r - W'(1);                       // [R1]
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== periodic_update_interrupt_sva.sv ====
// Purpose: port-level checks of the update interrupt block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   keeps its own copy of interrupt_control from bus writes
`timescale 1ns/1ps
`default_nettype none
module periodic_update_interrupt_sva #(
   parameter int RTN_SLOW = rtc_irq_pkg::RTN_SLOW_CYCLES,
   parameter int RTN_FAST = rtc_irq_pkg::RTN_FAST_CYCLES
) (
   // clock and reset
   input wire logic       clock,
   input wire logic       nrst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rdata,
   // interrupt pin
   input wire logic       irq_n_out,
   input wire logic       irq_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   logic [7:0] ctrl_r;
   int         hi_cnt_r;
   logic       in_map;
   logic       at_ctrl;
   logic       at_flags;
   // ==========================================================
   // address decode, mirror included
   assign in_map   = (addr[7:5] == 3'h0);
   assign at_ctrl  = in_map && (addr[3:0] == rtc_irq_pkg::OFS_IRQ_CTRL);
   assign at_flags = in_map && (addr[3:0] == rtc_irq_pkg::OFS_EVT_FLAGS);
   // shadow of the control register, no hardware-set bits there
   always_ff @(posedge clock) begin
      if (!nrst) ctrl_r <= 8'h00;
      else if (wr_stb && at_ctrl) ctrl_r <= wdata;
   end
   // length of the current low phase on the pin
   always_ff @(posedge clock) begin
      if (!nrst || !irq_oe) hi_cnt_r <= 0;
      else hi_cnt_r <= hi_cnt_r + 1;
   end
   // ==========================================================
   // register port
   property p_read_idle; !rd_stb |=> rdata == 8'h00; endproperty
   a_read_idle: assert property (p_read_idle) else $error("read data not idle");
   property p_ctrl_read; rd_stb && at_ctrl |=> rdata == (ctrl_r & rtc_irq_pkg::MASK_IRQ_CTRL); endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
   property p_flag_read; rd_stb && at_flags |=> (rdata & 8'hcf) == 8'h00; endproperty
   a_flag_read: assert property (p_flag_read) else $error("fixed flag bits not zero");
   // ==========================================================
   // interrupt pin
   property p_pin_level; irq_oe |-> irq_n_out == 1'b0; endproperty
   a_pin_level: assert property (p_pin_level) else $error("pin drives high");
   property p_flag_clear; wr_stb && at_flags && !wdata[5] && !ctrl_r[4] |=> !irq_oe; endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag clear kept pin low");
   property p_mask_fall; wr_stb && at_ctrl && wdata[5:4] == 2'b00 |=> !irq_oe; endproperty
   a_mask_fall: assert property (p_mask_fall) else $error("mask fall kept pin low");
   property p_hold_bound; hi_cnt_r <= RTN_SLOW; endproperty
   a_hold_bound: assert property (p_hold_bound) else $error("pin low too long");
   property p_hold_exact;
      $fell(irq_oe) && !$past(wr_stb) |-> hi_cnt_r == RTN_SLOW || hi_cnt_r == RTN_FAST;
   endproperty
   a_hold_exact: assert property (p_hold_exact) else $error("pin released early");
   property p_mask_gate; $past(ctrl_r[5:4]) == 2'b00 && ctrl_r[5:4] == 2'b00 |=> !$rose(irq_oe); endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("masked event drove pin");
   property p_reset_bit; ctrl_r[0] && $past(ctrl_r[0]) && !ctrl_r[4] |=> !$rose(irq_oe); endproperty
   a_reset_bit: assert property (p_reset_bit) else $error("event while clock held");
endmodule
bind rtc_update_irq periodic_update_interrupt_sva #(.RTN_SLOW(RTN_SLOW), .RTN_FAST(RTN_FAST)) u_sva (
   .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rdata(rdata), .irq_n_out(irq_n_out), .irq_oe(irq_oe));
`default_nettype wire

// ==== irq_host_model.sv ====
// Purpose: host side of the shared interrupt line
// Assumes: line has a pull-up at the host
// Notes:   another source may sink the line on its own
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
   // device pin
   input  wire logic irq_n_out,
   input  wire logic irq_oe,
   // other source on the same line
   input  wire logic other_low,
   // level seen by the host
   output logic      irq_line
);
   // pull-up unless some party sinks the line
   assign irq_line = other_low ? 1'b0 : (irq_oe ? irq_n_out : 1'b1);
endmodule
`default_nettype wire

// ==== periodic_update_interrupt_test.sv ====
// Purpose: self-checking bench of the update interrupt block
// Assumes: shortened timebase and release counts
// Notes:   one second is TDIV*4096 cycles here
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module periodic_update_interrupt_test;
   localparam int TDIV = 2;
   localparam int RSLOW = 20;
   localparam int SEC = TDIV * 4096;
   logic       clock = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr_stb = 1'b0;
   logic       rd_stb = 1'b0;
   logic       other_low = 1'b0;
   logic [7:0] rdata;
   logic       irq_n_out;
   logic       irq_oe;
   logic       irq_line;
   logic [7:0] d;
   int         n;
   int         cycles = 0;
   int         miscompares = 0;
   int         check_count = 0;
   rtc_update_irq #(.TICK_DIV(TDIV), .RTN_SLOW(RSLOW), .RTN_FAST(5)) dut (.clock(clock), .nrst(nrst),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .irq_n_out(irq_n_out), .irq_oe(irq_oe));
   irq_host_model host (.irq_n_out(irq_n_out), .irq_oe(irq_oe), .other_low(other_low), .irq_line(irq_line));
   always #5 clock = ~clock;
   // hang guard, about twice the planned run
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         miscompares++;
         $display("FAIL timeout");
         summarize();
      end
   end
   // ==========================================================
   // bus and wait helpers
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      @(posedge clock);
      d = rdata;
      `CHK(nm, e, d)
   endtask
   // bounded wait for the pin to be sunk
   task automatic wait_hi(input int lim);
      n = 0;
      while (irq_oe !== 1'b1 && n < lim) begin
         @(posedge clock);
         n++;
      end
   endtask
   // bounded count of the low phase on the pin
   task automatic wait_lo(input int lim);
      n = 0;
      while (irq_oe === 1'b1 && n < lim) begin
         @(posedge clock);
         n++;
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs();
      rchk("fsel rst", 8'h0d, 8'h00);
      rchk("flags rst", 8'h0e, 8'h00);
      rchk("ctrl rst", 8'h0f, 8'h00);
      wr(8'h1f, 8'hcf);
      rchk("ctrl mirror", 8'h0f, 8'hc9);
      wr(8'h0e, 8'hff);
      rchk("flags w1", 8'h1e, 8'h00);
      wr(8'h0d, 8'h2f);
      rchk("fsel mirror", 8'h1d, 8'h2f);
      rchk("unmapped", 8'h2e, 8'h00);
      wr(8'h0f, 8'h00);
      wr(8'h0d, 8'h00);
      $display("regs done");
   endtask
   task automatic t_countdown();
      wr(8'h0b, 8'h08);
      wr(8'h0c, 8'h00);
      wr(8'h0f, 8'h10);
      wr(8'h0d, 8'h10);
      wait_hi(40);
      `CHK("cd interval", 1'b1, irq_oe === 1'b1 && n >= 12 && n <= 20)
      wr(8'h0d, 8'h00);
      wr(8'h0f, 8'h00);
      wr(8'h0b, 8'h00);
      wr(8'h0f, 8'h10);
      wr(8'h0d, 8'h10);
      wait_hi(80);
      `CHK("cd zero", 1'b0, irq_oe)
      wr(8'h0d, 8'h00);
      wr(8'h0b, 8'h01);
      wr(8'h0d, 8'h11);
      wait_hi(300);
      `CHK("cd 64hz", 1'b1, irq_oe === 1'b1 && n <= 256)
      wait_lo(RSLOW + 10);
      `CHK("cd hold", RSLOW, n)
      wr(8'h0d, 8'h00);
      wr(8'h0f, 8'h00);
      $display("countdown done");
   endtask
   task automatic t_event();
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h20);
      wait_hi(SEC + 50);
      `CHK("irq rise", 1'b1, irq_oe)
      `CHK("line low", 1'b0, irq_line)
      wait_lo(RSLOW + 10);
      `CHK("hold", RSLOW, n)
      wait_hi(SEC);
      `CHK("period", SEC - RSLOW, n)
      rchk("flag set", 8'h0e, 8'h20);
      $display("event done");
   endtask
   task automatic t_clear();
      wr(8'h0e, 8'h20);
      `CHK("w1 no effect", 1'b1, irq_oe)
      wr(8'h0e, 8'h00);
      `CHK("clear release", 1'b0, irq_oe)
      rchk("flag cleared", 8'h0e, 8'h00);
      $display("clear done");
   endtask
   task automatic t_mask_fall();
      wait_hi(SEC + 50);
      `CHK("relow", 1'b1, irq_oe)
      wr(8'h0f, 8'h00);
      `CHK("mask release", 1'b0, irq_oe)
      rchk("flag kept", 8'h0e, 8'h20);
      $display("mask fall done");
   endtask
   task automatic t_mask_off();
      wr(8'h0e, 8'h00);
      wait_hi(SEC + 50);
      `CHK("masked", 1'b0, irq_oe)
      rchk("flag unmasked", 8'h0e, 8'h20);
      other_low <= 1'b1;
      @(posedge clock);
      `CHK("shared line", 1'b0, irq_line)
      other_low <= 1'b0;
      $display("mask off done");
   endtask
   task automatic t_reset_bit();
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h21);
      wait_hi(SEC + 50);
      `CHK("held pin", 1'b0, irq_oe)
      rchk("held flag", 8'h0e, 8'h00);
      wr(8'h0f, 8'h00);
      $display("reset bit done");
   endtask
   task automatic t_minute();
      wr(8'h0d, 8'h20);
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h20);
      wait_hi(SEC + 50);
      `CHK("minute pin", 1'b0, irq_oe)
      rchk("minute flag", 8'h0e, 8'h00);
      wr(8'h0f, 8'h00);
      $display("minute done");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      t_regs();
      t_countdown();
      t_event();
      t_clear();
      t_mask_fall();
      t_mask_off();
      t_reset_bit();
      t_minute();
      summarize();
   end
endmodule
`default_nettype wire
